/* ctf_pkg.sv */
// ctf_pkg: constants, carriers and state type of the can tx, filter and irq block
package ctf_pkg;
  // =====================================================
  // sizes and address map (byte addresses, one word each)
  localparam int NBUF = 3;
  localparam int NBYTE = 13;
  localparam int RANK = 13; // rank byte sits behind the 13 frame bytes
  localparam int RG_LO = 6;
  localparam int OF_LO = 2;
  localparam logic [8:0] A_RXF = 9'h000;
  localparam logic [8:0] A_RIE = 9'h004;
  localparam logic [8:0] A_TXF = 9'h008;
  localparam logic [8:0] A_TXC = 9'h00c;
  localparam logic [8:0] A_FLT = 9'h010;
  localparam logic [8:0] A_PAT = 9'h014;
  localparam logic [8:0] A_MSK = 9'h018;
  localparam logic [8:0] A_ERR = 9'h01c;
  localparam logic [2:0] R_TX0 = 3'h1; // tx buffers in regions 1..3
  localparam logic [2:0] R_FG = 3'h4; // foreground rx buffer
  // =====================================================
  // error counter limits
  localparam logic [8:0] LIM_WARN = 9'h060;
  localparam logic [8:0] LIM_PASS = 9'h07f;
  localparam logic [8:0] LIM_BOFF = 9'h0ff;
  // =====================================================
  // bit positions of flag/enable bytes and irq outputs
  localparam int F_RXF = 0;
  localparam int F_OVR = 1;
  localparam int F_BOFF = 2;
  localparam int F_TPAS = 3;
  localparam int F_RPAS = 4;
  localparam int F_TWRN = 5;
  localparam int F_RWRN = 6;
  localparam int F_WUP = 7;
  localparam int I_WUP = 0;
  localparam int I_ERR = 1;
  localparam int I_RX = 2;
  localparam int I_TX = 3;
  localparam int TXIE_LO = 4;
  localparam int HIT_LO = 8;
  localparam int TEC_LO = 16;
  // =====================================================
  // types
  typedef enum logic [1:0] {M_SINGLE = 2'h0, M_DUAL = 2'h1, M_QUAD = 2'h2} ctf_mode_t;
  typedef enum logic [1:0] {T_IDLE = 2'b01, T_BUSY = 2'b10} ctf_tx_t;
  typedef struct packed {
    logic arb;
    logic done;
    logic err;
    logic [3:0] raddr;
  } ctf_txin_t;
  typedef struct packed {
    logic sof;
    logic wr;
    logic [3:0] waddr;
    logic [7:0] wdata;
    logic eof;
    logic own;
  } ctf_rxin_t;
  typedef struct packed {
    logic [8:0] rec;
    logic [8:0] tec;
    logic sleep;
    logic act;
    logic gie;
  } ctf_stat_t;
  typedef struct packed {
    logic [NBUF-1:0][RANK:0][7:0] tb;
    logic [NBUF-1:0] tx_empty_flag;
    logic [NBUF-1:0] abr;
    logic [NBUF-1:0] abk;
    logic [NBUF-1:0] txie;
    ctf_tx_t tst;
    logic [1:0] cur;
    logic [NBYTE-1:0][7:0] bg;
    logic [NBYTE-1:0][7:0] fg;
    logic bgf;
    logic drop;
    logic [1:0] hit;
    logic [1:0] bghit;
    logic [7:0] fl;
    logic [7:0] ie;
    ctf_mode_t mode;
    logic [31:0] pat;
    logic [31:0] msk;
    logic epas;
    logic boff;
    logic [3:0] irq;
    logic ack;
    logic [31:0] rdat;
    logic [7:0] tbyte;
  } ctf_st_t;
endpackage : ctf_pkg

/* ctf_top.sv */
// ctf_top: tx buffering, acceptance filter and interrupt flags of a can node
// =====================================================
// What this block does
// - three tx buffers of thirteen bytes each
// - successful send sets empty flag and irq
// - smallest 8-bit rank among pending wins
// - selection repeats on every arbitration entry
// - abort granted unless buffer is being sent
// - abort_ack shows aborted one, sent zero
// - single mode matches full 32-bit pattern
// - dual mode: two 16-bit filters
// - quad mode: four 8-bit filters
// - mask bits set exclude pattern bits
// - only hit copies frame, sets full flag
// - lowest matching filter number reported
// - four irq outputs from eleven sources
// - local enables plus global mask gate sources
// - receive irq right after accepted frame end
// - bus activity in sleep sets wakeup flag
// - warning flags at error count 96
// - passive flags and state above 127
// - bus-off flag and state above 255
// - write one clears, not while cause persists
// - both rx buffers full: discard, overrun
//
// Our own choices: the register offsets and the Wishbone interface to the registers.
`timescale 1ns/1ns
module ctf_top (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [8:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire ctf_pkg::ctf_txin_t txin,
  input wire ctf_pkg::ctf_rxin_t rxin,
  input wire ctf_pkg::ctf_stat_t stat,
  output logic tx_pending,
  output logic tx_active,
  output logic [1:0] tx_buf,
  output logic [7:0] tx_byte,
  output logic irq_wakeup,
  output logic irq_error,
  output logic irq_rx,
  output logic irq_tx,
  output logic err_passive,
  output logic bus_off
);
  // =====================================================
  // state and helpers
  ctf_pkg::ctf_st_t st_r;
  ctf_pkg::ctf_st_t st_nxt;
  logic req;
  logic wr;
  logic [31:0] be;
  logic [31:0] wd;
  logic [31:0] rmux;
  logic [7:0] clr_rx;
  logic [2:0] clr_tx;
  logic [2:0] pend;
  logic [2:0] rg;
  logic [3:0] ro;
  logic [1:0] rb;
  logic found;
  logic [1:0] selb;
  logic [7:0] best;
  logic [31:0] id;
  logic [3:0] fhit;
  logic sgl;
  logic anyhit;
  logic [1:0] hidx;

  assign req = wb_cyc_i & wb_stb_i;
  assign wr = st_r.ack & req & wb_we_i;
  assign be = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
  assign wd = wb_dat_i & be;
  assign rg = wb_adr_i[ctf_pkg::RG_LO +: 3];
  assign ro = wb_adr_i[ctf_pkg::OF_LO +: 4];
  assign rb = 2'(rg[1:0] - 2'h1);
  // aborting buffers are not offered, so the abort can win the race
  assign pend = ~st_r.tx_empty_flag & ~st_r.abr;

  // =====================================================
  // acceptance filter on the first four identifier bytes
  assign id = {st_r.bg[0], st_r.bg[1], st_r.bg[2], st_r.bg[3]};
  assign sgl = &(~(id ^ st_r.pat) | st_r.msk);
  generate
    for (genvar k = 0; k < 4; k++) begin : g_flt
      logic q;
      logic d;
      // quad filter k looks at the first identifier byte only
      assign q = &(~(id[31:24] ^ st_r.pat[31-8*k -: 8]) | st_r.msk[31-8*k -: 8]);
      if (k < 2) begin : g_dual
        assign d = &(~(id[31:16] ^ st_r.pat[31-16*k -: 16]) | st_r.msk[31-16*k -: 16]);
      end else begin : g_nodual
        assign d = 1'b0;
      end
      assign fhit[k] = (st_r.mode == ctf_pkg::M_SINGLE) ? ((k == 0) && sgl) :
                       (st_r.mode == ctf_pkg::M_DUAL) ? d : q;
    end
  endgenerate
  assign anyhit = |fhit;
  // lowest filter wins, binary coded
  assign hidx = fhit[0] ? 2'h0 : fhit[1] ? 2'h1 : fhit[2] ? 2'h2 : 2'h3;

  // =====================================================
  // local rank selection, ties go to the lower buffer
  always_comb begin
    found = 1'b0;
    selb = 2'h0;
    best = 8'hff;
    for (int b = 0; b < ctf_pkg::NBUF; b++) begin
      if (pend[b] && (!found || st_r.tb[b][ctf_pkg::RANK] < best)) begin
        found = 1'b1;
        selb = 2'(b);
        best = st_r.tb[b][ctf_pkg::RANK];
      end
    end
  end

  // =====================================================
  // register read mux, unmapped words read zero
  always_comb begin
    rmux = 32'h0;
    case (wb_adr_i)
      ctf_pkg::A_RXF: rmux[7:0] = st_r.fl;
      ctf_pkg::A_RIE: rmux[7:0] = st_r.ie;
      ctf_pkg::A_TXF: rmux[6:0] = {st_r.abk, 1'b0, st_r.tx_empty_flag};
      ctf_pkg::A_TXC: rmux[6:0] = {st_r.txie, 1'b0, st_r.abr};
      ctf_pkg::A_FLT: begin
        rmux[1:0] = st_r.mode;
        rmux[ctf_pkg::HIT_LO +: 2] = st_r.hit;
      end
      ctf_pkg::A_PAT: rmux = st_r.pat;
      ctf_pkg::A_MSK: rmux = st_r.msk;
      ctf_pkg::A_ERR: begin
        rmux[8:0] = stat.rec;
        rmux[ctf_pkg::TEC_LO +: 9] = stat.tec;
      end
      default: begin
        if (rg >= ctf_pkg::R_TX0 && rg < ctf_pkg::R_FG && ro <= ctf_pkg::RANK) begin
          rmux[7:0] = st_r.tb[rb][ro];
        end else if (rg == ctf_pkg::R_FG && ro < ctf_pkg::NBYTE) begin
          rmux[7:0] = st_r.fg[ro];
        end
      end
    endcase
  end

  // =====================================================
  // next state
  always_comb begin
    st_nxt = st_r;
    clr_rx = 8'h0;
    clr_tx = 3'h0;
    // one wait state: ack in the cycle after the request is seen
    st_nxt.ack = req & ~st_r.ack;
    if (req && !st_r.ack) begin
      st_nxt.rdat = rmux;
    end
    // writes land on the edge where the master samples ack
    if (wr) begin
      case (wb_adr_i)
        ctf_pkg::A_RXF: clr_rx = wd[7:0];
        ctf_pkg::A_RIE: st_nxt.ie = wd[7:0];
        ctf_pkg::A_TXF: clr_tx = wd[2:0];
        ctf_pkg::A_TXC: begin
          st_nxt.abr = st_r.abr | wd[2:0];
          st_nxt.txie = wd[ctf_pkg::TXIE_LO +: 3];
        end
        ctf_pkg::A_FLT: begin
          if (wd[1:0] != 2'h3) begin
            st_nxt.mode = ctf_pkg::ctf_mode_t'(wd[1:0]);
          end
        end
        ctf_pkg::A_PAT: st_nxt.pat = (st_r.pat & ~be) | wd;
        ctf_pkg::A_MSK: st_nxt.msk = (st_r.msk & ~be) | wd;
        default: begin
          // a scheduled buffer is frozen so a frame cannot change in flight
          if (rg >= ctf_pkg::R_TX0 && rg < ctf_pkg::R_FG && ro <= ctf_pkg::RANK
              && st_r.tx_empty_flag[rb]) begin
            st_nxt.tb[rb][ro] = wd[7:0];
          end
        end
      endcase
    end

    // tx scheduling; host clears first so device sets win
    st_nxt.tx_empty_flag = st_r.tx_empty_flag & ~clr_tx;
    st_nxt.abk = st_r.abk & ~clr_tx;
    unique case (st_r.tst)
      ctf_pkg::T_IDLE: begin
      end
      ctf_pkg::T_BUSY: begin
        if (txin.done) begin
          st_nxt.tx_empty_flag[st_r.cur] = 1'b1;
          st_nxt.abk[st_r.cur] = 1'b0;
          st_nxt.abr[st_r.cur] = 1'b0;
          st_nxt.tst = ctf_pkg::T_IDLE;
        end else if (txin.err) begin
          st_nxt.tst = ctf_pkg::T_IDLE;
        end
      end
    endcase
    // every arbitration entry, retries included, picks afresh
    if (txin.arb && found) begin
      st_nxt.cur = selb;
      st_nxt.tst = ctf_pkg::T_BUSY;
    end
    // abort grant, refused while that buffer is on the bus
    for (int b = 0; b < ctf_pkg::NBUF; b++) begin
      if (st_r.abr[b]) begin
        if (st_r.tx_empty_flag[b]) begin
          st_nxt.abr[b] = 1'b0;
        end else if (!(st_r.tst == ctf_pkg::T_BUSY && st_r.cur == 2'(b))) begin
          st_nxt.tx_empty_flag[b] = 1'b1;
          st_nxt.abk[b] = 1'b1;
          st_nxt.abr[b] = 1'b0;
        end
      end
    end
    if (txin.raddr <= ctf_pkg::RANK) begin
      st_nxt.tbyte = st_r.tb[st_r.cur][txin.raddr];
    end

    // receive path
    st_nxt.fl = st_r.fl & ~clr_rx;
    if (rxin.sof) begin
      st_nxt.drop = st_r.bgf; // bg only stays full while fg is full
      if (st_r.bgf) begin
        st_nxt.fl[ctf_pkg::F_OVR] = 1'b1;
      end
    end
    if (rxin.wr && !st_r.drop && !st_r.bgf && rxin.waddr < ctf_pkg::NBYTE) begin
      st_nxt.bg[rxin.waddr] = rxin.wdata;
    end
    // own frames are never promoted; a held bg frame moves up once fg frees
    if (rxin.eof && !st_r.drop && !st_r.bgf && !rxin.own && anyhit) begin
      if (st_nxt.fl[ctf_pkg::F_RXF]) begin
        st_nxt.bgf = 1'b1;
        st_nxt.bghit = hidx;
      end else begin
        st_nxt.fg = st_r.bg;
        st_nxt.fl[ctf_pkg::F_RXF] = 1'b1;
        st_nxt.hit = hidx;
      end
    end else if (st_r.bgf && !st_nxt.fl[ctf_pkg::F_RXF]) begin
      st_nxt.fg = st_r.bg;
      st_nxt.fl[ctf_pkg::F_RXF] = 1'b1;
      st_nxt.hit = st_r.bghit;
      st_nxt.bgf = 1'b0;
    end

    // level causes re-set their flags each cycle, so a clear cannot stick
    if (stat.sleep && stat.act) begin
      st_nxt.fl[ctf_pkg::F_WUP] = 1'b1;
    end
    if (stat.rec >= ctf_pkg::LIM_WARN) begin
      st_nxt.fl[ctf_pkg::F_RWRN] = 1'b1;
    end
    if (stat.tec >= ctf_pkg::LIM_WARN) begin
      st_nxt.fl[ctf_pkg::F_TWRN] = 1'b1;
    end
    if (stat.rec > ctf_pkg::LIM_PASS) begin
      st_nxt.fl[ctf_pkg::F_RPAS] = 1'b1;
    end
    if (stat.tec > ctf_pkg::LIM_PASS) begin
      st_nxt.fl[ctf_pkg::F_TPAS] = 1'b1;
    end
    if (stat.tec > ctf_pkg::LIM_BOFF) begin
      st_nxt.fl[ctf_pkg::F_BOFF] = 1'b1;
    end
    st_nxt.epas = (stat.rec > ctf_pkg::LIM_PASS) | (stat.tec > ctf_pkg::LIM_PASS);
    st_nxt.boff = stat.tec > ctf_pkg::LIM_BOFF;

    // eleven sources onto four lines
    st_nxt.irq[ctf_pkg::I_WUP] = stat.gie & st_nxt.fl[ctf_pkg::F_WUP]
                                 & st_nxt.ie[ctf_pkg::F_WUP];
    st_nxt.irq[ctf_pkg::I_ERR] = stat.gie
      & |(st_nxt.fl[ctf_pkg::F_RWRN:ctf_pkg::F_OVR] & st_nxt.ie[ctf_pkg::F_RWRN:ctf_pkg::F_OVR]);
    st_nxt.irq[ctf_pkg::I_RX] = stat.gie & st_nxt.fl[ctf_pkg::F_RXF]
                                & st_nxt.ie[ctf_pkg::F_RXF];
    st_nxt.irq[ctf_pkg::I_TX] = stat.gie & |(st_nxt.tx_empty_flag & st_nxt.txie);

    if (!rst_n) begin
      st_nxt = '0;
      st_nxt.tx_empty_flag = '1;
      st_nxt.tst = ctf_pkg::T_IDLE;
      st_nxt.mode = ctf_pkg::M_SINGLE;
    end
  end

  // single state register, reset folded into st_nxt
  always_ff @(posedge clk_sys) begin
    st_r <= st_nxt;
  end

  // =====================================================
  // outputs
  assign wb_ack_o = st_r.ack;
  assign wb_dat_o = st_r.rdat;
  assign tx_pending = |pend;
  assign tx_active = st_r.tst == ctf_pkg::T_BUSY;
  assign tx_buf = st_r.cur;
  assign tx_byte = st_r.tbyte;
  assign irq_wakeup = st_r.irq[ctf_pkg::I_WUP];
  assign irq_error = st_r.irq[ctf_pkg::I_ERR];
  assign irq_rx = st_r.irq[ctf_pkg::I_RX];
  assign irq_tx = st_r.irq[ctf_pkg::I_TX];
  assign err_passive = st_r.epas;
  assign bus_off = st_r.boff;

  // =====================================================
  // assertions
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_n);

  property p_done;
    st_r.tst == ctf_pkg::T_BUSY && txin.done && !txin.arb |=>
      st_r.tx_empty_flag[$past(st_r.cur)] && !st_r.abk[$past(st_r.cur)] && !tx_active;
  endproperty
  a_done: assert property (p_done) else $error("sent buffer not released");

  property p_rank;
    txin.arb && pend[0] && pend[1] && st_r.tb[0][ctf_pkg::RANK] < st_r.tb[1][ctf_pkg::RANK]
      |=> tx_active && tx_buf != 2'h1;
  endproperty
  a_rank: assert property (p_rank) else $error("higher rank value chosen");

  property p_abort;
    st_r.abr[1] && !st_r.tx_empty_flag[1] && st_r.tst == ctf_pkg::T_IDLE |=>
      st_r.tx_empty_flag[1] && st_r.abk[1] && !st_r.abr[1];
  endproperty
  a_abort: assert property (p_abort) else $error("abort not granted");

  property p_noabort;
    tx_active && tx_buf == 2'h0 && !txin.done && !txin.err && !st_r.abk[0]
      && !$past(txin.arb) |=> !st_r.abk[0];
  endproperty
  a_noabort: assert property (p_noabort) else $error("abort of frame on bus");

  property p_single;
    st_r.mode == ctf_pkg::M_SINGLE && rxin.eof && !rxin.own && !st_r.drop && !st_r.bgf
      && !st_r.fl[ctf_pkg::F_RXF] && id == st_r.pat |=> st_r.fl[ctf_pkg::F_RXF] && st_r.hit == 2'h0;
  endproperty
  a_single: assert property (p_single) else $error("exact id not accepted");

  property p_nohit;
    rxin.eof && !anyhit && !st_r.fl[ctf_pkg::F_RXF] && !st_r.bgf |=> !st_r.fl[ctf_pkg::F_RXF];
  endproperty
  a_nohit: assert property (p_nohit) else $error("frame kept without hit");

  // a clear may stick once the count has dropped back below the limit
  property p_warn;
    stat.tec >= ctf_pkg::LIM_WARN |=> st_r.fl[ctf_pkg::F_TWRN]
      ##1 (st_r.fl[ctf_pkg::F_TWRN] || $past(stat.tec) < ctf_pkg::LIM_WARN);
  endproperty
  a_warn: assert property (p_warn) else $error("tx warning missing");

  property p_boff;
    stat.tec > ctf_pkg::LIM_BOFF |=> bus_off && err_passive && st_r.fl[ctf_pkg::F_BOFF];
  endproperty
  a_boff: assert property (p_boff) else $error("bus off missing");

  property p_clr;
    st_r.fl[ctf_pkg::F_OVR] && clr_rx[ctf_pkg::F_OVR] && !rxin.sof |=> !st_r.fl[ctf_pkg::F_OVR];
  endproperty
  a_clr: assert property (p_clr) else $error("overrun clear failed");

  property p_ovr;
    rxin.sof && st_r.bgf |=> st_r.fl[ctf_pkg::F_OVR] && st_r.drop;
  endproperty
  a_ovr: assert property (p_ovr) else $error("overrun not flagged");

  property p_wup;
    stat.sleep && stat.act && stat.gie && st_r.ie[ctf_pkg::F_WUP] |=> irq_wakeup;
  endproperty
  a_wup: assert property (p_wup) else $error("wakeup irq missing");

  property p_ack;
    req && !wb_ack_o |=> wb_ack_o;
  endproperty
  a_ack: assert property (p_ack) else $error("bus ack late");

  c_sent: cover property (tx_active && txin.done);
  c_abort: cover property (st_r.abr[1] ##1 st_r.abk[1]);
  c_quad: cover property (st_r.mode == ctf_pkg::M_QUAD && rxin.eof && fhit[3] && !fhit[0]);
  c_ovr: cover property (rxin.sof && st_r.bgf);
endmodule : ctf_top

/* ctf_can_model.sv */
// ctf_can_model: behavioural can engine and bus status source for the bench
`timescale 1ns/1ns
module ctf_can_model (
  input wire logic clk_sys,
  output ctf_pkg::ctf_txin_t txin,
  output ctf_pkg::ctf_rxin_t rxin,
  output ctf_pkg::ctf_stat_t stat
);
  // =========================
  // quiet link and zero error counts at time zero
  initial begin
    txin = '0;
    rxin = '0;
    stat = '0;
  end
  // =========================
  // engine enters arbitration; it always fetches byte 0
  task automatic arb_go();
    @(posedge clk_sys);
    txin.arb <= 1'b1;
    @(posedge clk_sys);
    txin.arb <= 1'b0;
  endtask : arb_go
  // attempt ends sent or failed; done or err is driven high for one cycle, then both drop
  task automatic fin(input logic ok);
    @(posedge clk_sys);
    txin.done <= ok;
    txin.err <= !ok;
    @(posedge clk_sys);
    txin.done <= 1'b0;
    txin.err <= 1'b0;
  endtask : fin
  // =========================
  // one valid frame: start, thirteen bytes, end of frame
  task automatic frame(input logic [31:0] id);
    @(posedge clk_sys);
    rxin.sof <= 1'b1;
    for (int i = 0; i < 13; i++) begin
      @(posedge clk_sys);
      rxin.sof <= 1'b0;
      rxin.wr <= 1'b1;
      rxin.waddr <= 4'(i);
      rxin.wdata <= (i < 4) ? id[31-8*i -: 8] : 8'(i);
    end
    @(posedge clk_sys);
    rxin.wr <= 1'b0;
    rxin.eof <= 1'b1;
    @(posedge clk_sys);
    rxin.eof <= 1'b0;
    rxin.wdata <= ~rxin.wdata; // idle data must not look like the last byte
  endtask : frame
endmodule : ctf_can_model

/* test_can_tx_filter_irq.sv */
// test_can_tx_filter_irq: self-checking bench of the can tx, filter and irq block
`timescale 1ns/1ns
module test_can_tx_filter_irq;
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [8:0] adr = 9'h0;
  logic [31:0] wdat = 32'h0;
  logic [31:0] rdat;
  logic ack, tx_pending, tx_active, irq_wakeup, irq_error, irq_rx, irq_tx, err_passive, bus_off;
  logic [1:0] tx_buf;
  logic [7:0] tx_byte;
  ctf_pkg::ctf_txin_t txin;
  ctf_pkg::ctf_rxin_t rxin;
  ctf_pkg::ctf_stat_t stat;
  int failures = 0;
  int n_checks = 0;
  int seed = 32'h61684ccb;
  // rec, tec, sleep, activity, expected flag byte
  logic [27:0] ev [10] = '{{9'd95, 9'd0, 2'b00, 8'h00}, {9'd96, 9'd0, 2'b00, 8'h40},
    {9'd127, 9'd0, 2'b00, 8'h40}, {9'd128, 9'd0, 2'b00, 8'h50}, {9'd0, 9'd96, 2'b00, 8'h20},
    {9'd0, 9'd128, 2'b00, 8'h28}, {9'd0, 9'd255, 2'b00, 8'h28}, {9'd0, 9'd256, 2'b00, 8'h2c},
    {9'd0, 9'd0, 2'b11, 8'h80}, {9'd0, 9'd0, 2'b01, 8'h00}};
  // =========================
  // 10 mhz clock
  always #50 clk_sys = ~clk_sys;
  ctf_can_model u_can (.clk_sys(clk_sys), .txin(txin), .rxin(rxin), .stat(stat));
  ctf_top u_dut (.clk_sys(clk_sys), .rst_n(rst_n), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_dat_o(rdat),
    .wb_ack_o(ack), .txin(txin), .rxin(rxin), .stat(stat), .tx_pending(tx_pending),
    .tx_active(tx_active), .tx_buf(tx_buf), .tx_byte(tx_byte), .irq_wakeup(irq_wakeup),
    .irq_error(irq_error), .irq_rx(irq_rx), .irq_tx(irq_tx), .err_passive(err_passive),
    .bus_off(bus_off));
  // =========================
  // verdict, reached from the end of the run and from any timeout
  task automatic complete_run();
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : complete_run
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // classic cycle; the request stands until ack is sampled high
  task automatic wb(input logic w, input logic [8:0] a, input logic [31:0] d,
                    output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clk_sys);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do begin
      @(posedge clk_sys);
      n++;
    end while (ack !== 1'b1 && n < 20);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    if (n >= 20) begin
      failures++;
      complete_run();
    end
  endtask : wb
  task automatic wr(input logic [8:0] a, input logic [31:0] d);
    logic [31:0] q;
    wb(1'b1, a, d, q);
  endtask : wr
  task automatic rd(input logic [8:0] a, input logic [31:0] e);
    logic [31:0] q;
    wb(1'b0, a, 32'h0, q);
    chk(q, e);
  endtask : rd
  // =========================
  // expected winner: smallest rank, lower index on a tie
  function automatic logic [1:0] pick(input logic [2:0] p, input logic [7:0] k [3]);
    logic [1:0] s;
    s = 2'h3;
    for (int b = 0; b < 3; b++)
      if (p[b] && (s == 2'h3 || k[b] < k[s])) s = 2'(b);
    return s;
  endfunction : pick
  // expected {hit, index}; descending loop leaves the lowest matching filter
  function automatic logic [2:0] filt(input logic [1:0] m, input logic [31:0] p, k, id);
    logic [2:0] r;
    r = 3'h0;
    for (int f = 3; f >= 0; f--) begin
      if (m == 2'h2 && ((id[31:24] ^ p[31-8*f -: 8]) & ~k[31-8*f -: 8]) == 8'h0) r = {1'b1, 2'(f)};
      if (m == 2'h1 && f < 2 && ((id[31:16] ^ p[31-16*f -: 16]) & ~k[31-16*f -: 16]) == 16'h0)
        r = {1'b1, 2'(f)};
    end
    if (m == 2'h0 && ((id ^ p) & ~k) == 32'h0) r = 3'h4;
    return r;
  endfunction : filt
  // =========================
  // main sequence
  initial begin
    logic [7:0] rk [3];
    logic [7:0] b0 [3];
    logic [2:0] pend;
    logic [1:0] e;
    logic [1:0] m;
    logic [2:0] h;
    logic [31:0] p, k, id, f, q;
    repeat (12) @(posedge clk_sys);
    rst_n <= 1'b1;
    rd(ctf_pkg::A_TXF, 32'h7);
    rd(ctf_pkg::A_FLT, 32'h0);
    rd(9'h020, 32'h0);
    u_can.stat.gie <= 1'b1;
    wr(ctf_pkg::A_TXC, 32'h70);
    // priority rounds, last one with equal ranks
    for (int r = 0; r < 4; r++) begin
      for (int b = 0; b < 3; b++) begin
        rk[b] = (r == 3) ? 8'h05 : 8'($random(seed));
        b0[b] = 8'($random(seed));
        wr(9'(64 * (b + 1)), {24'h0, b0[b]});
        wr(9'(64 * (b + 1) + 52), {24'h0, rk[b]});
      end
      wr(ctf_pkg::A_TXF, 32'h7);
      pend = 3'h7;
      u_can.arb_go();
      u_can.fin(1'b0);
      for (int n = 0; n < 3; n++) begin
        e = pick(pend, rk);
        u_can.arb_go();
        repeat (2) @(posedge clk_sys);
        chk(tx_buf, e);
        chk(tx_byte, b0[e]);
        u_can.fin(1'b1);
        pend[e] = 1'b0;
        rd(ctf_pkg::A_TXF, {29'h0, ~pend});
      end
      chk(irq_tx, 1'b1);
    end
    wr(ctf_pkg::A_TXC, 32'h0);
    // the irq line is launched by the edge that ends the write
    @(posedge clk_sys);
    chk(irq_tx, 1'b0);
    wr(ctf_pkg::A_TXC, 32'h70);
    u_can.stat.gie <= 1'b0;
    repeat (3) @(posedge clk_sys);
    chk(irq_tx, 1'b0);
    u_can.stat.gie <= 1'b1;
    $display("test tx priority done");
    // abort off the bus, then abort while on the bus
    wr(ctf_pkg::A_TXF, 32'h2);
    wr(ctf_pkg::A_TXC, 32'h72);
    rd(ctf_pkg::A_TXF, 32'h27);
    wr(ctf_pkg::A_TXF, 32'h4);
    u_can.arb_go();
    chk(tx_pending, 1'b1);
    wr(ctf_pkg::A_TXC, 32'h74);
    rd(ctf_pkg::A_TXF, 32'h23);
    chk(tx_active, 1'b1);
    chk(tx_pending, 1'b0);
    u_can.fin(1'b1);
    rd(ctf_pkg::A_TXF, 32'h27);
    chk(tx_active, 1'b0);
    $display("test abort done");
    // error counts, wakeup and clears against live causes
    wr(ctf_pkg::A_RIE, 32'hff);
    foreach (ev[i]) begin
      u_can.stat.rec <= ev[i][27:19];
      u_can.stat.tec <= ev[i][18:10];
      u_can.stat.sleep <= ev[i][9];
      u_can.stat.act <= ev[i][8];
      repeat (3) @(posedge clk_sys);
      wr(ctf_pkg::A_RXF, 32'hff);
      rd(ctf_pkg::A_RXF, {24'h0, ev[i][7:0]});
      chk(irq_error, |ev[i][6:1]);
      chk(irq_wakeup, ev[i][7]);
      chk(err_passive, ev[i][4] | ev[i][3]);
      chk(bus_off, ev[i][2]);
      u_can.stat <= '{rec: 9'h0, tec: 9'h0, sleep: 1'b0, act: 1'b0, gie: 1'b1};
      repeat (3) @(posedge clk_sys);
      wr(ctf_pkg::A_RXF, 32'hff);
      rd(ctf_pkg::A_RXF, 32'h0);
    end
    $display("test error flags done");
    // corner: exact id in single mode, nothing masked
    wr(ctf_pkg::A_PAT, 32'h1234abcd);
    u_can.frame(32'h1234abcd);
    repeat (2) @(posedge clk_sys);
    rd(ctf_pkg::A_RXF, 32'h1);
    rd(ctf_pkg::A_FLT, 32'h0);
    wr(ctf_pkg::A_RXF, 32'h1);
    // random filters in all three modes
    for (int i = 0; i < 36; i++) begin
      m = 2'(i % 3);
      id = $random(seed);
      k = $random(seed);
      f = $random(seed) & $random(seed) & ((i % 2) ? k : 32'hffffffff);
      p = ((m == 2'h0) ? id : (m == 2'h1) ? {2{id[31:16]}} : {4{id[31:24]}}) ^ f;
      wr(ctf_pkg::A_FLT, {30'h0, m});
      wr(ctf_pkg::A_PAT, p);
      wr(ctf_pkg::A_MSK, k);
      u_can.frame(id);
      h = filt(m, p, k, id);
      repeat (2) @(posedge clk_sys);
      chk(irq_rx, h[2]);
      rd(ctf_pkg::A_RXF, {31'h0, h[2]});
      if (h[2]) begin
        rd(ctf_pkg::A_FLT, {22'h0, h[1:0], 6'h0, m});
        rd(9'h100, {24'h0, id[31:24]});
        wr(ctf_pkg::A_RXF, 32'h1);
      end
    end
    wr(ctf_pkg::A_FLT, 32'h3);
    wb(1'b0, ctf_pkg::A_FLT, 32'h0, q);
    chk(q[1:0], 2'h2);
    $display("test filters done");
    // third frame with both rx buffers full
    wr(ctf_pkg::A_MSK, 32'hffffffff);
    repeat (3) u_can.frame($random(seed));
    rd(ctf_pkg::A_RXF, 32'h3);
    chk(irq_error, 1'b1);
    wr(ctf_pkg::A_RXF, 32'h3);
    rd(ctf_pkg::A_RXF, 32'h1);
    wr(ctf_pkg::A_RXF, 32'h3);
    rd(ctf_pkg::A_RXF, 32'h0);
    // own frame passes every filter but must never reach the host
    u_can.rxin.own <= 1'b1;
    u_can.frame($random(seed));
    u_can.rxin.own <= 1'b0;
    repeat (2) @(posedge clk_sys);
    rd(ctf_pkg::A_RXF, 32'h0);
    $display("test overrun done");
    complete_run();
  end
endmodule : test_can_tx_filter_irq
